/* src/sweb_params.svh */
`ifndef SWEB_PARAMS_SVH
`define SWEB_PARAMS_SVH
// Register offsets (word index on the plain port)
`define SWEB_ADDR_CMD      4'h0
`define SWEB_ADDR_STATE    4'h1
`define SWEB_ADDR_CFG      4'h2
`define SWEB_ADDR_IRQ_STAT 4'h3
`define SWEB_ADDR_IRQ_MASK 4'h4
`define SWEB_ADDR_EVT      4'h5
`define SWEB_ADDR_TIME     4'h6
`define SWEB_ADDR_NAME     4'h7
`define SWEB_ADDR_NAME_IDX 4'h8
// Switch count and name size
`define SWEB_NUM_SW        5
`define SWEB_NAME_LEN      32
// Event numbering and event word field positions
`define SWEB_SW_FIRST      3'h1
`define SWEB_EVT_SW_LSB    0
`define SWEB_EVT_ON_BIT    4
`define SWEB_EVT_VALID_BIT 8
// Config field positions and reset values
`define SWEB_CFG_LVL_LSB   0
`define SWEB_CFG_SEL_LSB   2
`define SWEB_CFG_RESET     32'h0000_000E
// Default name characters
`define SWEB_CHAR_S        8'h53
`define SWEB_CHAR_0        8'h30
// Interrupt bit positions
`define SWEB_IRQ_EVT       0
`define SWEB_IRQ_REJ       1
`define SWEB_IRQ_OVF       2
`endif

/* src/sweb_pkg.sv */
package sweb_pkg;
  // Access levels, lowest first
  typedef enum logic [1:0] {
    SWEB_LVL_USER = 2'h0,
    SWEB_LVL_OPER = 2'h1,
    SWEB_LVL_CONF = 2'h2,
    SWEB_LVL_SUPER = 2'h3
  } sweb_level_type;
  // Which event kinds are stored
  typedef enum logic [1:0] {
    SWEB_SEL_NONE = 2'h0,
    SWEB_SEL_ON = 2'h1,
    SWEB_SEL_OFF = 2'h2,
    SWEB_SEL_BOTH = 2'h3
  } sweb_select_type;
endpackage

/* src/sweb_switch_block.sv */
`timescale 1ns/1ps
`include "sweb_params.svh"
// Summary of operation
// RULE1 - Each switch output holds its last commanded state until the opposite command.
// RULE2 - Only the local mimic and remote terminal unit ports command switches.
// RULE3 - No digital input or logic signal can change a switch output.
// RULE4 - Five independent switches, each with own output, commands and events.
// RULE5 - Each output change raises an event with switch number and new state; of two changes in one cycle only the lower switch raises one.
// RULE6 - Selection stores ON, OFF or both event kinds; others are dropped.
// RULE7 - Each stored event carries the time stamp of its status change.
// RULE8 - Mimic commands below the configured access level are rejected.
// RULE9 - Each switch has a 32-character name, default label Switch number; reset loads S and the number digit.
// RULE10 - Commanding the state already held changes nothing and raises no event.
module sweb_switch_block
  import sweb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Local mimic command (same clock domain)
  input wire logic mimic_valid_i,
  input wire logic [2:0] mimic_sw_i,
  input wire logic mimic_on_i,
  input wire logic [1:0] mimic_level_i,
  // Remote terminal unit command (same clock domain)
  input wire logic rtu_valid_i,
  input wire logic [2:0] rtu_sw_i,
  input wire logic rtu_on_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Switch outputs and event stream
  output logic [`SWEB_NUM_SW-1:0] switch_o,
  output logic evt_valid_o,
  output logic [2:0] evt_sw_o,
  output logic evt_on_o,
  output logic [31:0] evt_time_o,
  output logic irq_o
);

  logic [31:0] cfg;
  logic [`SWEB_NUM_SW-1:0] sw_state;
  logic [31:0] time_cnt;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [31:0] evt_word;
  logic [31:0] evt_stamp;
  logic evt_full;
  logic [7:0] name_idx;
  logic [7:0] name_mem [`SWEB_NUM_SW*`SWEB_NAME_LEN];
  sweb_level_type need_lvl;
  sweb_select_type sel;
  logic mimic_ok;
  logic mimic_rej;
  logic [`SWEB_NUM_SW-1:0] set_on;
  logic [`SWEB_NUM_SW-1:0] set_off;
  logic [`SWEB_NUM_SW-1:0] chg;
  logic [`SWEB_NUM_SW-1:0] next_state;
  logic store;
  logic [2:0] store_sw;
  logic store_on;
  logic rd_evt;
  logic wr_cfg;
  logic wr_mask;
  logic wr_idx;
  logic wr_name;
  logic wr_stat;
  logic name_hit;
  logic evt_lost;
  logic [2:0] store_num;

  assign need_lvl = sweb_level_type'(cfg[`SWEB_CFG_LVL_LSB +: 2]);
  assign sel = sweb_select_type'(cfg[`SWEB_CFG_SEL_LSB +: 2]);
  assign rd_evt = reg_rd_i && (reg_addr_i == `SWEB_ADDR_EVT);
  // Write decodes; the command offset matches none, so only the ports command
  assign wr_cfg = reg_wr_i && (reg_addr_i == `SWEB_ADDR_CFG);
  assign wr_mask = reg_wr_i && (reg_addr_i == `SWEB_ADDR_IRQ_MASK);
  assign wr_idx = reg_wr_i && (reg_addr_i == `SWEB_ADDR_NAME_IDX);
  assign wr_name = reg_wr_i && (reg_addr_i == `SWEB_ADDR_NAME); // RULE9
  assign wr_stat = reg_wr_i && (reg_addr_i == `SWEB_ADDR_IRQ_STAT);
  // Pointer beyond the last name byte reads zero and writes nowhere
  assign name_hit = name_idx < 8'(`SWEB_NUM_SW * `SWEB_NAME_LEN);
  // Switch numbers count from one on the event side
  assign store_num = store_sw + `SWEB_SW_FIRST; // RULE5
  // Stored event replaced before software read it
  assign evt_lost = store && evt_full && !rd_evt;

  // Mimic gated by operator level
  assign mimic_ok = mimic_valid_i && (mimic_level_i >= need_lvl); // RULE8
  assign mimic_rej = mimic_valid_i && !mimic_ok; // RULE8

  // Per-switch command decode; RTU first, then mimic, first source wins
  genvar g;
  generate
    for (g = 0; g < `SWEB_NUM_SW; g++) begin : gen_sw // RULE4
      always_comb begin
        set_on[g] = 1'b0;
        set_off[g] = 1'b0;
        // Only these two sources exist; no other input reaches here
        if (rtu_valid_i && rtu_sw_i == 3'(g)) begin // RULE2 RULE3
          set_on[g] = rtu_on_i;
          set_off[g] = !rtu_on_i;
        end else if (mimic_ok && mimic_sw_i == 3'(g)) begin // RULE2
          set_on[g] = mimic_on_i;
          set_off[g] = !mimic_on_i;
        end
        next_state[g] = set_on[g] ? 1'b1 : (set_off[g] ? 1'b0 : sw_state[g]); // RULE1
        chg[g] = next_state[g] != sw_state[g]; // RULE10
      end
    end
  endgenerate

  // Switch latches
  // Reset opens every switch; no commanded state survives a reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_state <= '0;
    end else begin
      sw_state <= next_state; // RULE1
    end
  end

  // Free-running time base for stamps
  // Wraps after 2^32 cycles; software must unwrap very long gaps
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      time_cnt <= 32'h0;
    end else begin
      time_cnt <= time_cnt + 32'h1;
    end
  end

  // Pick the lowest changed switch; commands hit one switch per source
  // Lowest index wins so the choice never depends on timing
  always_comb begin
    store = 1'b0;
    store_sw = 3'h0;
    store_on = 1'b0;
    for (int i = `SWEB_NUM_SW - 1; i >= 0; i--) begin
      if (chg[i]) begin
        store_sw = 3'(i);
        store_on = next_state[i];
      end
    end
    if (|chg) begin
      store = store_on ? sel[0] : sel[1]; // RULE6
    end
  end

  // Second simultaneous change is rare (two sources, one cycle); it is lost
  // Event stream to the main buffer, one cycle pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_valid_o <= 1'b0;
      evt_sw_o <= 3'h0;
      evt_on_o <= 1'b0;
      evt_time_o <= 32'h0;
    end else begin
      evt_valid_o <= store; // RULE5 RULE6
      if (store) begin
        evt_sw_o <= store_num; // RULE5
        evt_on_o <= store_on;
        evt_time_o <= time_cnt; // RULE7
      end
    end
  end

  // Last event holding register for software
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_word <= 32'h0;
      evt_stamp <= 32'h0;
      evt_full <= 1'b0;
    end else begin
      if (store) begin
        evt_word <= 32'h0;
        evt_word[`SWEB_EVT_VALID_BIT] <= 1'b1;
        evt_word[`SWEB_EVT_ON_BIT] <= store_on;
        evt_word[`SWEB_EVT_SW_LSB +: 3] <= store_num; // RULE5
        evt_stamp <= time_cnt; // RULE7
        evt_full <= 1'b1;
      end else if (rd_evt) begin
        evt_full <= 1'b0;
      end
    end
  end

  // Configuration and name pointer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= `SWEB_CFG_RESET; // RULE8
      irq_mask <= 3'h0;
      name_idx <= 8'h0;
    end else if (reg_wr_i) begin
      if (wr_cfg) begin
        cfg <= {28'h0, reg_wdata_i[3:0]};
      end
      if (wr_mask) begin
        irq_mask <= reg_wdata_i[2:0];
      end
      if (wr_idx) begin
        name_idx <= reg_wdata_i[7:0];
      end
    end
  end

  // Name storage; reset loads the Sn default, S then the switch number digit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < `SWEB_NUM_SW * `SWEB_NAME_LEN; i++) begin
        name_mem[i] <= 8'h00;
      end
      for (int s = 0; s < `SWEB_NUM_SW; s++) begin
        name_mem[s*`SWEB_NAME_LEN] <= `SWEB_CHAR_S; // RULE9
        name_mem[s*`SWEB_NAME_LEN+1] <= `SWEB_CHAR_0 + 8'(s + 1); // RULE9
      end
    end else if (wr_name && name_hit) begin
      name_mem[name_idx] <= reg_wdata_i[7:0]; // RULE9
    end
  end

  // Event-stored flag; set wins over write-one-to-clear so no event is missed
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat[`SWEB_IRQ_EVT] <= 1'b0;
    end else if (store) begin
      irq_stat[`SWEB_IRQ_EVT] <= 1'b1; // RULE5
    end else if (wr_stat && reg_wdata_i[`SWEB_IRQ_EVT]) begin
      irq_stat[`SWEB_IRQ_EVT] <= 1'b0;
    end
  end

  // Rejected-mimic flag; set wins over write-one-to-clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat[`SWEB_IRQ_REJ] <= 1'b0;
    end else if (mimic_rej) begin
      irq_stat[`SWEB_IRQ_REJ] <= 1'b1; // RULE8
    end else if (wr_stat && reg_wdata_i[`SWEB_IRQ_REJ]) begin
      irq_stat[`SWEB_IRQ_REJ] <= 1'b0;
    end
  end

  // Overwrite flag; the holding register keeps only the newest event
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat[`SWEB_IRQ_OVF] <= 1'b0;
    end else if (evt_lost) begin
      irq_stat[`SWEB_IRQ_OVF] <= 1'b1;
    end else if (wr_stat && reg_wdata_i[`SWEB_IRQ_OVF]) begin
      irq_stat[`SWEB_IRQ_OVF] <= 1'b0;
    end
  end

  // Interrupt level registered so the pin never glitches
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Switch outputs mirror the latches from flip-flops of their own
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      switch_o <= '0;
    end else begin
      switch_o <= next_state; // RULE1
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `SWEB_ADDR_STATE: reg_rdata_o <= {27'h0, sw_state};
        `SWEB_ADDR_CFG: reg_rdata_o <= cfg;
        `SWEB_ADDR_IRQ_STAT: reg_rdata_o <= {29'h0, irq_stat};
        `SWEB_ADDR_IRQ_MASK: reg_rdata_o <= {29'h0, irq_mask};
        `SWEB_ADDR_EVT: reg_rdata_o <= evt_full ? evt_word : 32'h0;
        `SWEB_ADDR_TIME: reg_rdata_o <= evt_stamp;
        `SWEB_ADDR_NAME: reg_rdata_o <= name_hit ? {24'h0, name_mem[name_idx]} : 32'h0;
        `SWEB_ADDR_NAME_IDX: reg_rdata_o <= {24'h0, name_idx};
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // Command offset is write-only and inert; switches move only from the ports
endmodule // sweb_switch_block

/* verification/sweb_switch_block_assertions.sv */
`timescale 1ns/1ps
// Switch outputs, event stream and read port against the command inputs
module sweb_switch_block_assertions (
  // Clock, reset and inputs
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mimic_valid_i,
  input wire logic [2:0] mimic_sw_i,
  input wire logic mimic_on_i,
  input wire logic [1:0] mimic_level_i,
  input wire logic rtu_valid_i,
  input wire logic [2:0] rtu_sw_i,
  input wire logic rtu_on_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_rd_i,
  // Outputs
  input wire logic [31:0] reg_rdata_o,
  input wire logic [4:0] switch_o,
  input wire logic evt_valid_o,
  input wire logic [2:0] evt_sw_o,
  input wire logic evt_on_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_switch_hold: assert property (!mimic_valid_i && !rtu_valid_i |=> $stable(switch_o))
    else $error("switch moved without command");
  a_remote_sets: assert property (rtu_valid_i && rtu_sw_i < 3'h5
    |=> switch_o[$past(rtu_sw_i)] == $past(rtu_on_i)) else $error("remote command lost");
  a_super_sets: assert property (mimic_valid_i && mimic_level_i == 2'h3 && mimic_sw_i < 3'h5
    && !rtu_valid_i |=> switch_o[$past(mimic_sw_i)] == $past(mimic_on_i))
    else $error("mimic command lost");
  a_same_quiet: assert property (rtu_valid_i && rtu_sw_i < 3'h5 && !mimic_valid_i
    && switch_o[rtu_sw_i] == rtu_on_i |=> $stable(switch_o) && !evt_valid_o)
    else $error("repeat command acted");
  a_bad_index: assert property (rtu_valid_i && rtu_sw_i > 3'h4 && !mimic_valid_i
    |=> $stable(switch_o)) else $error("bad index acted");
  a_evt_fields: assert property (evt_valid_o |-> evt_sw_o inside {[3'h1:3'h5]}
    && switch_o[evt_sw_o - 3'h1] == evt_on_o) else $error("event fields wrong");
  a_evt_change: assert property (evt_valid_o |-> switch_o != $past(switch_o))
    else $error("event without change");
  a_state_read: assert property (reg_rd_i && reg_addr_i == 4'h1
    |=> reg_rdata_o == {27'h0, $past(switch_o)}) else $error("state read wrong");
endmodule // sweb_switch_block_assertions

bind sweb_switch_block sweb_switch_block_assertions i_sweb_switch_block_assertions (.*);

/* verification/sweb_cmd_model.sv */
`timescale 1ns/1ps
// Mimic and remote unit command sources
module sweb_cmd_model (
  input wire logic clk_i,
  // Command fields
  output logic mimic_valid_o = 1'b0,
  output logic [2:0] mimic_sw_o = 3'h0,
  output logic mimic_on_o = 1'b0,
  output logic [1:0] mimic_level_o = 2'h0,
  output logic rtu_valid_o = 1'b0,
  output logic [2:0] rtu_sw_o = 3'h0,
  output logic rtu_on_o = 1'b0
);
  // One-cycle command; switch and state fields flip once the strobe drops (the level is held) so stale values never match
  task automatic issue(input bit r, input logic [2:0] s, input logic o, input logic [1:0] l);
    @(posedge clk_i);
    if (r) {rtu_valid_o, rtu_sw_o, rtu_on_o} <= {1'b1, s, o};
    else {mimic_valid_o, mimic_sw_o, mimic_on_o, mimic_level_o} <= {1'b1, s, o, l};
    @(posedge clk_i);
    {rtu_valid_o, rtu_sw_o, rtu_on_o} <= {1'b0, ~rtu_sw_o, ~rtu_on_o};
    {mimic_valid_o, mimic_sw_o, mimic_on_o} <= {1'b0, ~mimic_sw_o, ~mimic_on_o};
  endtask
endmodule // sweb_cmd_model

/* verification/sweb_switch_block_tb.sv */
`timescale 1ns/1ps
`include "sweb_params.svh"
// Random and directed commands against a scoreboard of switch states
module sweb_switch_block_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic mv, mo, rv, ro, ev, eo, irq;
  logic [2:0] ms, rs, es;
  logic [1:0] ml;
  logic [31:0] rdata, et, t_last, t_first;
  logic [4:0] sw, exp_sw = 5'h0;
  logic [3:0] cfg = 4'hE, last_evt;
  int err_count = 0, checks_done = 0, n_evt = 0, exp_evt = 0, seed = 61;
  sweb_cmd_model i_sweb_cmd_model (.clk_i(clk_i), .mimic_valid_o(mv), .mimic_sw_o(ms),
    .mimic_on_o(mo), .mimic_level_o(ml), .rtu_valid_o(rv), .rtu_sw_o(rs), .rtu_on_o(ro));
  sweb_switch_block i_sweb_switch_block (.clk_i, .rst_i, .mimic_valid_i(mv), .mimic_sw_i(ms),
    .mimic_on_i(mo), .mimic_level_i(ml), .rtu_valid_i(rv), .rtu_sw_i(rs), .rtu_on_i(ro),
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata), .switch_o(sw),
    .evt_valid_o(ev), .evt_sw_o(es), .evt_on_o(eo), .evt_time_o(et), .irq_o(irq));
  // Clock
  initial forever #2 clk_i = ~clk_i;
  // Pulses last one cycle, so they are counted at the edge that ends them
  always @(posedge clk_i) begin
    if (ev === 1'b1) begin
      n_evt <= n_evt + 1;
      last_evt <= {es, eo};
      t_last <= et;
    end
  end
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check(rdata, e);
  endtask
  // Whether an event of this kind is stored
  function automatic logic kept(input logic o, input logic [3:0] c);
    return o ? c[2] : c[3];
  endfunction
  task automatic cmd(input bit r, input logic [2:0] s, input logic o, input logic [1:0] l);
    logic k;
    k = 1'b0;
    i_sweb_cmd_model.issue(r, s, o, l);
    if ((r || l >= cfg[1:0]) && s < 3'h5 && exp_sw[s] !== o) begin
      exp_sw[s] = o;
      k = kept(o, cfg);
      exp_evt += k;
    end
    repeat (2) @(posedge clk_i);
    #1 check(sw, exp_sw);
    check(n_evt, exp_evt);
    if (k) check(last_evt, {s + 3'h1, o});
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SWEB_ADDR_CFG, `SWEB_CFG_RESET);
    wr(4'h9, 32'hFFFF);
    rd(4'h9, 32'h0);
    wr(`SWEB_ADDR_CMD, 32'h1F);
    rd(`SWEB_ADDR_STATE, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`SWEB_ADDR_NAME_IDX, i * 32 + 1);
      rd(`SWEB_ADDR_NAME, `SWEB_CHAR_0 + i + 1);
    end
    wr(`SWEB_ADDR_NAME, 32'h41);
    rd(`SWEB_ADDR_NAME, 32'h41);
    for (int i = 0; i < 60; i++)
      cmd($random(seed), {$random(seed)} % 6, $random(seed), $random(seed));
    for (int i = 0; i < 10; i++) cmd(1, i % 5, 1'b1, 2'h0);
    wr(`SWEB_ADDR_IRQ_STAT, 32'h7);
    wr(`SWEB_ADDR_IRQ_MASK, 32'h2);
    cmd(0, 3'h0, 1'b0, 2'h1);
    check(irq, 1'b1);
    wr(`SWEB_ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 check(irq, 1'b0);
    rd(`SWEB_ADDR_IRQ_STAT, 32'h2);
    wr(`SWEB_ADDR_IRQ_STAT, 32'h2);
    rd(`SWEB_ADDR_IRQ_STAT, 32'h0);
    for (int m = 0; m < 4; m++) begin
      cfg = {m[1:0], 2'h2};
      wr(`SWEB_ADDR_CFG, cfg);
      cmd(1, 3'h4, ~exp_sw[4], 2'h0);
      cmd(1, 3'h4, ~exp_sw[4], 2'h0);
    end
    cmd(1, 3'h2, ~exp_sw[2], 2'h0);
    t_first = t_last;
    repeat (10) @(posedge clk_i);
    cmd(1, 3'h2, ~exp_sw[2], 2'h0);
    check(t_last - t_first, 32'hE);
    rd(`SWEB_ADDR_EVT, {23'h0, 1'b1, 3'h0, exp_sw[2], 4'h3});
    rd(`SWEB_ADDR_EVT, 32'h0);
    rd(`SWEB_ADDR_IRQ_STAT, 32'h5);
    test_done();
  end
endmodule // sweb_switch_block_tb
